// ---- src/asof_defs.svh ----
//------------------------------------------------------------------------
// Purpose: Constants of the serial output formatter
//------------------------------------------------------------------------
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef ASOF_DEFS_SVH
`define ASOF_DEFS_SVH
// Word widths
`define ASOF_SMP_W      12
`define ASOF_CFG_W      6
// Overdrive clamp codes
`define ASOF_POS_OBIN   12'hFFF
`define ASOF_POS_TWOS   12'h7FF
`define ASOF_NEG_OBIN   12'h000
`define ASOF_NEG_TWOS   12'h800
// Test pattern words
`define ASOF_ALT_A      12'hAAA
`define ASOF_ALT_B      12'h555
`define ASOF_ALL_ONES   12'hFFF
`define ASOF_ALL_ZERO   12'h000
// Serial geometry, bits per wire
`define ASOF_WBITS_12   4'hC
`define ASOF_WBITS_14   4'hE
`define ASOF_WIRE_MAX   4'hE
// Sync pattern leading ones per wire
`define ASOF_SYNC_1W    4'h6
`define ASOF_SYNC_2W12  4'h3
`define ASOF_SYNC_2W14  4'h4
// Drive current codes: 3.5, 2.5, 3.0, 4.5 mA
`define ASOF_DRV_3P5    2'h0
`define ASOF_DRV_2P5    2'h1
`define ASOF_DRV_3P0    2'h2
`define ASOF_DRV_4P5    2'h3
`define ASOF_TERM_NONE  5'h00
`endif

// ---- src/asof_pkg.sv ----
//------------------------------------------------------------------------
// Purpose: Types of the serial output formatter
//------------------------------------------------------------------------
// Assumes: Used with full package scope, never imported
// Notes:   Constants live in asof_defs.svh
package asof_pkg;
   typedef enum logic [2:0] {
      ASOF_PAT_NONE   = 3'h0,
      ASOF_PAT_ZERO   = 3'h1,
      ASOF_PAT_ONES   = 3'h2,
      ASOF_PAT_TOGGLE = 3'h3,
      ASOF_PAT_CUSTOM = 3'h4,
      ASOF_PAT_SYNC   = 3'h5,
      ASOF_PAT_DESKEW = 3'h6,
      ASOF_PAT_RSVD   = 3'h7
   } asof_pat_type;
   typedef enum logic [1:0] {
      ASOF_ORD_ONE  = 2'h0,
      ASOF_ORD_BYTE = 2'h1,
      ASOF_ORD_BIT  = 2'h2,
      ASOF_ORD_WORD = 2'h3
   } asof_order_type;
   typedef struct packed {
      asof_order_type order;
      logic           ser14;
      logic           ddr;
      logic           lsb_first;
      logic           sync_sel;
   } asof_cfg_type;
   typedef struct packed {
      logic [3:0][11:0] code;
      logic [3:0]       ovr_pos;
      logic [3:0]       ovr_neg;
   } asof_samples_type;
   typedef struct packed {
      logic [1:0] drive_current_select;
      logic       drive_current_doubler;
      logic [4:0] term_clk;
      logic [4:0] term_data;
   } asof_drive_type;
   typedef struct packed {
      logic chan_a_wire_lo;
      logic chan_a_wire_hi;
      logic chan_b_wire_lo;
      logic chan_b_wire_hi;
      logic chan_c_wire_lo;
      logic chan_c_wire_hi;
      logic chan_d_wire_lo;
      logic chan_d_wire_hi;
   } asof_wires_type;
endpackage : asof_pkg

// ---- src/asof_sync.sv ----
//------------------------------------------------------------------------
// Purpose: Three-stage synchroniser with agreement filter
//------------------------------------------------------------------------
// Assumes: Input is quasi-static or a toggle
// Notes:   Stage one feeds stage two only
`timescale 1ns/1ps
module asof_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] out_r;

   // Capture chain, change counts once stages agree
   always_ff @(posedge i_clk) begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (!i_rst_n) begin
         out_r <= '0;
      end else if (s2_r == s3_r) begin
         out_r <= s3_r;
      end
   end
   assign o_sync = out_r;
endmodule : asof_sync

// ---- src/asof_format.sv ----
//------------------------------------------------------------------------
// Purpose: Output code format and overdrive clamp for one channel
//------------------------------------------------------------------------
// Assumes: Raw sample is offset binary from the converter core
// Notes:   Pure combinational
`timescale 1ns/1ps
`include "asof_defs.svh"
module asof_format (
   input  wire logic [11:0] i_raw,
   input  wire logic        i_ovr_pos,
   input  wire logic        i_ovr_neg,
   input  wire logic        i_offset_bin,
   output logic      [11:0] o_code
);
   wire [11:0] twos_code = {~i_raw[11], i_raw[10:0]};
   wire [11:0] pos_code  = i_offset_bin ? `ASOF_POS_OBIN : `ASOF_POS_TWOS;
   wire [11:0] neg_code  = i_offset_bin ? `ASOF_NEG_OBIN : `ASOF_NEG_TWOS;
   wire [11:0] lin_code  = i_offset_bin ? i_raw : twos_code;

   // Clamp first, then format select
   assign o_code = i_ovr_pos ? pos_code :
                   i_ovr_neg ? neg_code : lin_code;
endmodule : asof_format

// ---- src/asof_top.sv ----
//------------------------------------------------------------------------
// Purpose: Four-channel serial output formatter and serialiser
//------------------------------------------------------------------------
// Assumes: i_link_clk runs free at twice the serial bit rate
// Notes:   Words cross to the link domain by a toggle handshake
`timescale 1ns/1ps
`include "asof_defs.svh"
module asof_top (
   input  wire logic                      i_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_link_clk,
   input  wire logic                      i_sample_valid,
   input  wire asof_pkg::asof_samples_type i_samples,
   input  wire logic                      i_code_format_select,
   input  wire asof_pkg::asof_order_type  i_order,
   input  wire logic                      i_ser14,
   input  wire logic                      i_ddr,
   input  wire logic                      i_lsb_first,
   input  wire asof_pkg::asof_pat_type    i_pattern,
   input  wire logic [5:0]                i_custom_msb,
   input  wire logic [5:0]                i_custom_lsb,
   input  wire asof_pkg::asof_drive_type  i_drive,
   output asof_pkg::asof_drive_type       o_drive,
   output asof_pkg::asof_wires_type       o_wires,
   output logic                           o_serial_bit_clock,
   output logic                           o_frame_clock
);
   //---------------------------------------------------------------------
   // Functions
   //---------------------------------------------------------------------
   // Pattern word for one sample slot
   function automatic logic [11:0] pat_word(
      input asof_pkg::asof_pat_type pat,
      input logic                   ph,
      input logic [11:0]            custom
   );
      logic [11:0] w;
      w = `ASOF_ALL_ZERO;
      case (pat)
         asof_pkg::ASOF_PAT_ONES:   w = `ASOF_ALL_ONES;
         asof_pkg::ASOF_PAT_TOGGLE: w = ph ? `ASOF_ALT_B : `ASOF_ALT_A;
         asof_pkg::ASOF_PAT_CUSTOM: w = custom;
         asof_pkg::ASOF_PAT_DESKEW: w = `ASOF_ALT_A;
         default:                   w = `ASOF_ALL_ZERO;
      endcase
      return w;
   endfunction : pat_word

   // Bits of one wire, MSB first, right aligned
   function automatic logic [13:0] split(
      input logic [13:0]              w,
      input asof_pkg::asof_order_type ord,
      input logic [3:0]               nslot,
      input logic                     hi
   );
      logic [13:0] r;
      r = 14'h0000;
      case (ord)
         asof_pkg::ASOF_ORD_ONE:  r = hi ? 14'h0000 : w;
         asof_pkg::ASOF_ORD_BYTE: r = hi ? (w >> nslot)
                                         : (w & ~(14'h3FFF << nslot));
         asof_pkg::ASOF_ORD_BIT: begin
            for (int i = 0; i < 7; i++) begin
               r[i] = w[2*i + (hi ? 1 : 0)];
            end
         end
         asof_pkg::ASOF_ORD_WORD: r = w;
      endcase
      return r;
   endfunction : split

   // Left align for MSB first, or reverse for LSB first
   function automatic logic [13:0] place(
      input logic [13:0] m,
      input logic [3:0]  len,
      input logic        lsb
   );
      logic [13:0] r;
      r = m << (`ASOF_WIRE_MAX - len);
      if (lsb) begin
         for (int i = 0; i < 14; i++) begin
            r[13-i] = m[i];
         end
      end
      return r;
   endfunction : place

   //---------------------------------------------------------------------
   // System domain: format, sample hold, pattern select
   //---------------------------------------------------------------------
   asof_pkg::asof_cfg_type   cfg_s;
   asof_pkg::asof_drive_type drive_r;
   logic [3:0][11:0]         fmt_code;
   logic [3:0][11:0]         cur_r;
   logic [3:0][11:0]         prev_r;
   logic [3:0][11:0]         hold0_r;
   logic [3:0][11:0]         hold1_r;
   logic [3:0][11:0]         hold0_nxt;
   logic [3:0][11:0]         hold1_nxt;
   logic                     ack_s_r;
   logic                     tog_r;
   logic                     req_s;
   logic                     req_l_r;

   // Link config word and pairing of samples per frame
   assign cfg_s = {i_order, i_ser14, i_ddr, i_lsb_first,
                   i_pattern == asof_pkg::ASOF_PAT_SYNC};
   wire pair_s  = (i_order == asof_pkg::ASOF_ORD_WORD) ||
                  (i_ser14 && i_ddr && i_order != asof_pkg::ASOF_ORD_ONE);
   wire pat_on  = i_pattern != asof_pkg::ASOF_PAT_NONE &&
                  i_pattern != asof_pkg::ASOF_PAT_RSVD;
   wire capture = req_s != ack_s_r;
   wire [11:0] custom  = {i_custom_msb, i_custom_lsb};
   wire [11:0] pat_w0  = pat_word(i_pattern, tog_r, custom);
   wire [11:0] pat_w1  = pat_word(i_pattern, ~tog_r, custom);

   // Per-channel format stage
   for (genvar g = 0; g < 4; g++) begin : g_fmt
      asof_format u_fmt (
         .i_raw        (i_samples.code[g]),
         .i_ovr_pos    (i_samples.ovr_pos[g]),
         .i_ovr_neg    (i_samples.ovr_neg[g]),
         .i_offset_bin (i_code_format_select),
         .o_code       (fmt_code[g])
      );
      assign hold0_nxt[g] = pat_on ? pat_w0 :
                            (pair_s ? prev_r[g] : cur_r[g]);
      assign hold1_nxt[g] = pat_on ? pat_w1 : cur_r[g];
   end

   // Request from link domain
   asof_sync #(.W(1)) u_req (
      .i_clk   (i_clk),
      .i_rst_n (i_resetn),
      .i_async (req_l_r),
      .o_sync  (req_s)
   );

   // Sample history and word hand-off
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cur_r   <= '0;
         prev_r  <= '0;
         hold0_r <= '0;
         hold1_r <= '0;
         ack_s_r <= 1'b0;
         tog_r   <= 1'b0;
      end else begin
         if (i_sample_valid) begin
            cur_r  <= fmt_code;
            prev_r <= cur_r;
         end
         if (capture) begin
            hold0_r <= hold0_nxt;
            hold1_r <= hold1_nxt;
            ack_s_r <= req_s;
            tog_r   <= pair_s ? tog_r : ~tog_r;
         end
      end
   end

   // Buffer drive and termination controls
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         drive_r <= {`ASOF_DRV_3P5, 1'b0, `ASOF_TERM_NONE,
                     `ASOF_TERM_NONE};
      end else begin
         drive_r <= i_drive;
      end
   end
   assign o_drive = drive_r;

   //---------------------------------------------------------------------
   // Link domain: crossing and serialiser
   //---------------------------------------------------------------------
   asof_pkg::asof_cfg_type cfg_l;
   logic                   ack_l;
   logic                   link_rstn;
   logic                   ph_r;
   logic [3:0]             cnt_r;
   logic                   ack_seen_r;
   logic                   bclk_r;
   logic                   frame_r;
   logic [3:0][11:0]       nxt0_r;
   logic [3:0][11:0]       nxt1_r;
   logic [3:0][11:0]       cur1_r;
   logic [3:0][13:0]       lo_sh_r;
   logic [3:0][13:0]       hi_sh_r;

   // Reset and config into link domain
   asof_sync #(.W(1)) u_rst (
      .i_clk   (i_link_clk),
      .i_rst_n (1'b1),
      .i_async (i_resetn),
      .o_sync  (link_rstn)
   );
   asof_sync #(.W(`ASOF_CFG_W + 1)) u_cfg (
      .i_clk   (i_link_clk),
      .i_rst_n (link_rstn),
      .i_async ({ack_s_r, cfg_s}),
      .o_sync  ({ack_l, cfg_l})
   );

   // Frame geometry from mode
   wire       one_l  = cfg_l.order == asof_pkg::ASOF_ORD_ONE;
   wire       ww_l   = cfg_l.order == asof_pkg::ASOF_ORD_WORD;
   wire [3:0] wbits  = cfg_l.ser14 ? `ASOF_WBITS_14
                                   : `ASOF_WBITS_12;
   wire [3:0] nslot  = one_l ? wbits : (wbits >> 1);
   wire       pair_l = ww_l || (cfg_l.ser14 && cfg_l.ddr && !one_l);
   wire [3:0] flen   = pair_l ? (nslot << 1) : nslot;
   wire [3:0] len    = ww_l ? wbits : nslot;
   wire [3:0] cnt_nxt = (cnt_r == flen - 4'h1) ? 4'h0 : cnt_r + 4'h1;
   wire [4:0] half   = (5'(flen) + 5'h01) >> 1;
   wire       fstart = cnt_nxt == 4'h0;
   wire       load   = fstart || (pair_l && !ww_l && cnt_nxt == nslot);
   wire       got    = ack_l != ack_seen_r;

   // Sync pattern per wire
   wire [3:0]  sync_k  = one_l ? `ASOF_SYNC_1W :
                         (cfg_l.ser14 ? `ASOF_SYNC_2W14 : `ASOF_SYNC_2W12);
   wire [13:0] sync_p  = (~(14'h3FFF << sync_k)) << (nslot - sync_k);
   wire [13:0] sync_m  = ww_l ? ((sync_p << nslot) | sync_p)
                              : sync_p;

   // Per-channel wire words and shifters
   for (genvar c = 0; c < 4; c++) begin : g_ser
      wire [11:0] src_a = fstart ? nxt0_r[c] : cur1_r[c];
      wire [13:0] w_a   = {2'b00, src_a};
      wire [13:0] w_b   = {2'b00, nxt1_r[c]};
      wire [13:0] lo_m  = cfg_l.sync_sel ? sync_m
                          : split(w_a, cfg_l.order, nslot, 1'b0);
      wire [13:0] hi_m  = cfg_l.sync_sel ? (one_l ? 14'h0000 : sync_m)
                          : split(ww_l ? w_b : w_a, cfg_l.order,
                                  nslot, 1'b1);
      wire [13:0] lo_ld = place(lo_m, len, cfg_l.lsb_first);
      wire [13:0] hi_ld = place(hi_m, len, cfg_l.lsb_first);

      always_ff @(posedge i_link_clk) begin
         if (!link_rstn) begin
            lo_sh_r[c] <= 14'h0000;
            hi_sh_r[c] <= 14'h0000;
         end else if (ph_r) begin
            lo_sh_r[c] <= load ? lo_ld : (lo_sh_r[c] << 1);
            hi_sh_r[c] <= load ? hi_ld : (hi_sh_r[c] << 1);
         end
      end
   end

   // Bit phase, frame counter, clocks and word request
   always_ff @(posedge i_link_clk) begin
      if (!link_rstn) begin
         ph_r    <= 1'b0;
         cnt_r   <= 4'hF;        // Wraps to zero, first bit opens a frame
         bclk_r  <= 1'b0;
         frame_r <= 1'b0;
         req_l_r <= 1'b0;
         cur1_r  <= '0;
      end else begin
         ph_r   <= ~ph_r;
         bclk_r <= cfg_l.ddr ? (ph_r ? bclk_r : ~bclk_r) : ~ph_r;
         if (ph_r) begin
            cnt_r   <= cnt_nxt;
            frame_r <= 5'(cnt_nxt) < half;
            if (fstart) begin
               req_l_r <= ~req_l_r;
               cur1_r  <= nxt1_r;
            end
         end
      end
   end

   // Take handed-off words once the acknowledge arrives
   always_ff @(posedge i_link_clk) begin
      if (!link_rstn) begin
         ack_seen_r <= 1'b0;
         nxt0_r     <= '0;
         nxt1_r     <= '0;
      end else if (got) begin
         ack_seen_r <= ack_l;
         nxt0_r     <= hold0_r;
         nxt1_r     <= hold1_r;
      end
   end

   // Output pins from flip-flops
   assign o_serial_bit_clock = bclk_r;
   assign o_frame_clock      = frame_r;
   assign o_wires = {lo_sh_r[0][13], hi_sh_r[0][13],
                     lo_sh_r[1][13], hi_sh_r[1][13],
                     lo_sh_r[2][13], hi_sh_r[2][13],
                     lo_sh_r[3][13], hi_sh_r[3][13]};

   //---------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------
   a_frame_start: assert property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      $rose(frame_r) |-> cnt_r == 4'h0 && !ph_r)
      else $error("frame rise not at word start");
   a_pad_zeros: assert property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      (cfg_l.ser14 && one_l && !cfg_l.lsb_first && !cfg_l.sync_sel &&
       cnt_r == 4'h0 && !ph_r) |-> lo_sh_r[0][13:12] == 2'b00)
      else $error("14x word lacks zero padding");
   a_rate_14x_sdr: assert property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      (cfg_l.order == asof_pkg::ASOF_ORD_BYTE && cfg_l.ser14 &&
       !cfg_l.ddr) ##0 $rose(frame_r) |-> ##14 $rose(frame_r))
      else $error("14x sdr frame not seven bits");
   a_rate_12x_byte: assert property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      (cfg_l.order == asof_pkg::ASOF_ORD_BYTE && !cfg_l.ser14) ##0
      $rose(frame_r) |-> ##12 $rose(frame_r))
      else $error("12x frame not six bits");
   a_rate_word: assert property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      (ww_l && !cfg_l.ser14) ##0 $rose(frame_r) |->
      ##24 $rose(frame_r))
      else $error("word-wise frame not half rate");
   a_rate_14x_ddr: assert property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      (cfg_l.order == asof_pkg::ASOF_ORD_BIT && cfg_l.ser14 &&
       cfg_l.ddr) ##0 $rose(frame_r) |-> ##28 $rose(frame_r))
      else $error("14x ddr frame not half rate");
   a_bclk_mid: assert property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      (!cfg_l.ddr && ph_r) |=> !bclk_r ##1 bclk_r)
      else $error("bit clock edge not mid bit");
   a_ovr_pos: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_samples.ovr_pos[0]) |-> fmt_code[0] ==
      (i_code_format_select ? `ASOF_POS_OBIN : `ASOF_POS_TWOS))
      else $error("positive clamp wrong");
   a_ovr_neg: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (i_samples.ovr_neg[1] && !i_samples.ovr_pos[1]) |-> fmt_code[1] ==
      (i_code_format_select ? `ASOF_NEG_OBIN : `ASOF_NEG_TWOS))
      else $error("negative clamp wrong");
   a_pat_all_chan: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (capture && i_pattern == asof_pkg::ASOF_PAT_ONES) |=>
      hold0_r == {4{`ASOF_ALL_ONES}} && hold1_r == hold0_r)
      else $error("pattern not on all channels");
   a_toggle_alt: assert property (@(posedge i_clk)
      disable iff (!i_resetn)
      (capture && i_pattern == asof_pkg::ASOF_PAT_TOGGLE) |=>
      hold1_r[2] == ~hold0_r[2] && (hold0_r[2] == `ASOF_ALT_A ||
      hold0_r[2] == `ASOF_ALT_B))
      else $error("toggle words do not alternate");
   a_drive_reset: assert property (@(posedge i_clk)
      !i_resetn |=> o_drive.drive_current_select == `ASOF_DRV_3P5)
      else $error("drive current default wrong");
   c_word_frame: cover property (@(posedge i_link_clk)
      disable iff (!link_rstn) ww_l && $rose(frame_r));
   c_sync_frame: cover property (@(posedge i_link_clk)
      disable iff (!link_rstn) cfg_l.sync_sel && $rose(frame_r));
   c_lsb_ddr: cover property (@(posedge i_link_clk)
      disable iff (!link_rstn)
      cfg_l.lsb_first && cfg_l.ddr && $rose(frame_r));
endmodule : asof_top

// ---- sim/asof_rx_model.sv ----
//------------------------------------------------------------------------
// Purpose: Receiver model deserialising all eight data wires
// Assumes: Bits stand two link cycles, frame rises on first bit
// Notes:   A word is the run of bits between two frame rises
`timescale 1ns/1ps
module asof_rx_model (
   input  wire logic                     i_link_clk,
   input  wire asof_pkg::asof_wires_type i_wires,
   input  wire logic                     i_frame_clock,
   output logic [7:0][13:0]              o_words,
   output logic [7:0]                    o_period,
   output logic [15:0]                   o_frames
);
   logic [7:0][13:0] sh_r;
   logic [7:0]       cyc_r = 8'h00;
   logic             fr_r = 1'b0;
   logic             ph_r = 1'b0;
   initial o_frames = 16'h0000;
   // Align to each frame rise, then take a bit every second edge
   always @(posedge i_link_clk) begin
      fr_r <= i_frame_clock;
      cyc_r <= cyc_r + 8'h01;
      ph_r <= ~ph_r;
      if (i_frame_clock && !fr_r) begin
         o_words <= sh_r;
         o_period <= cyc_r;
         o_frames <= o_frames + 16'h0001;
         cyc_r <= 8'h01;
         ph_r <= 1'b1;
         for (int i = 0; i < 8; i++) begin
            sh_r[i] <= {13'h0000, i_wires[i]};
         end
      end else if (!ph_r) begin
         for (int i = 0; i < 8; i++) begin
            sh_r[i] <= {sh_r[i][12:0], i_wires[i]};
         end
      end
   end
endmodule : asof_rx_model

// ---- sim/testbench.sv ----
//------------------------------------------------------------------------
// Purpose: Self-checking bench of the serial output formatter
// Assumes: Samples are held constant so frames repeat
// Notes:   Each run checks the last full frame on a, d wires
`timescale 1ns/1ps
module testbench;
   logic                     clk = 1'b0;
   logic                     link_clk = 1'b0;
   logic                     resetn = 1'b0;
   logic                     sample_valid = 1'b0;
   asof_pkg::asof_samples_type samples = '0;
   asof_pkg::asof_order_type order = asof_pkg::ASOF_ORD_ONE;
   asof_pkg::asof_pat_type   pattern = asof_pkg::ASOF_PAT_NONE;
   asof_pkg::asof_drive_type drive = '0;
   asof_pkg::asof_drive_type drive_q;
   asof_pkg::asof_wires_type wires;
   logic                     fmt = 1'b0;
   logic                     ser14 = 1'b0;
   logic                     ddr = 1'b0;
   logic                     lsb_first = 1'b0;
   logic                     bclk;
   logic                     frame;
   logic [7:0][13:0]         words;
   logic [7:0]               period;
   logic [15:0]              frames;
   int                       error_cnt = 0;
   int                       total_checks = 0;
   always #25 clk = ~clk;
   initial begin
      #7;
      forever #62.5 link_clk = ~link_clk;
   end
   // Sample strobe every other cycle
   always @(negedge clk) sample_valid <= ~sample_valid;
   asof_top asof_top_i (.i_clk(clk), .i_resetn(resetn),
      .i_link_clk(link_clk), .i_sample_valid(sample_valid),
      .i_samples(samples), .i_code_format_select(fmt), .i_order(order),
      .i_ser14(ser14), .i_ddr(ddr), .i_lsb_first(lsb_first),
      .i_pattern(pattern), .i_custom_msb(6'h2D), .i_custom_lsb(6'h1A),
      .i_drive(drive), .o_drive(drive_q), .o_wires(wires),
      .o_serial_bit_clock(bclk), .o_frame_clock(frame));
   asof_rx_model asof_rx_model_i (.i_link_clk(link_clk), .i_wires(wires),
      .i_frame_clock(frame), .o_words(words), .o_period(period),
      .o_frames(frames));
   task automatic stop_test();
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [13:0] e, g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Set a mode, let four frames pass, compare the last one
   task automatic run(input int o, s, d, l, p, f, ov, elo, ehi, per);
      int          n;
      logic [13:0] m;
      @(negedge clk);
      resetn = 1'b0;
      order = asof_pkg::asof_order_type'(o[1:0]);
      pattern = asof_pkg::asof_pat_type'(p[2:0]);
      ser14 = s[0];
      ddr = d[0];
      lsb_first = l[0];
      fmt = f[0];
      samples = {{4{12'hA53}}, {4{ov[1]}}, {4{ov[0]}}};
      // Mode changes only under reset, so frames never break mid-word
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      n = frames + 4;
      for (int i = 0; i < 4000 && frames < n; i++) @(negedge clk);
      if (frames < n) begin
         error_cnt++;
         stop_test();
      end
      m = 14'h3FFF >> (14 - per / 2);
      chk("period", 14'(per), {6'h00, period});
      chk("a_lo", 14'(elo), words[7] & m);
      chk("a_hi", 14'(ehi), words[6] & m);
      chk("d_lo", 14'(elo), words[1] & m);
   endtask : run
   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      chk("drive", 14'h0000, {1'b0, drive_q});
      drive = {2'h3, 1'b1, 5'h11, 5'h0A};
      repeat (2) @(negedge clk);
      chk("drive", 14'h1E2A, {1'b0, drive_q});
      run(0, 0, 0, 0, 0, 0, 0, 'h253, 0, 24);
      run(0, 0, 0, 0, 0, 1, 0, 'hA53, 0, 24);
      run(0, 0, 0, 0, 0, 0, 2, 'h7FF, 0, 24);
      run(0, 0, 0, 0, 0, 1, 2, 'hFFF, 0, 24);
      run(0, 0, 0, 0, 0, 0, 1, 'h800, 0, 24);
      run(0, 0, 0, 0, 0, 1, 1, 'h000, 0, 24);
      run(0, 1, 0, 0, 0, 0, 0, 'h253, 0, 28);
      run(1, 0, 0, 0, 0, 0, 0, 'h13, 'h09, 12);
      run(1, 0, 0, 1, 0, 0, 0, 'h32, 'h24, 12);
      run(2, 0, 0, 0, 0, 1, 0, 'h0D, 'h31, 12);
      run(1, 1, 0, 0, 0, 1, 0, 'h53, 'h14, 14);
      run(1, 1, 1, 0, 0, 1, 0, 'h29D3, 'h0A14, 28);
      run(3, 0, 0, 0, 0, 1, 0, 'hA53, 'hA53, 24);
      run(3, 0, 0, 0, 3, 1, 0, 'hAAA, 'h555, 24);
      run(0, 0, 0, 0, 1, 1, 2, 'h000, 0, 24);
      run(0, 0, 0, 0, 2, 1, 0, 'hFFF, 0, 24);
      run(0, 0, 0, 0, 6, 1, 0, 'hAAA, 0, 24);
      run(0, 0, 0, 0, 5, 1, 0, 'hFC0, 0, 24);
      run(0, 1, 0, 0, 5, 1, 0, 'h3F00, 0, 28);
      run(1, 0, 0, 0, 5, 1, 0, 'h38, 'h38, 12);
      run(0, 0, 0, 0, 4, 1, 0, 'hB5A, 0, 24);
      run(0, 0, 0, 0, 0, 1, 0, 'hA53, 0, 24);
      stop_test();
   end
endmodule : testbench
